// File: wwds_mcu_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// monitored controller: issues trigger pulses on request
// ----------------------------------------------------------------
module wwds_mcu_model
(
    input wire logic clk,
    output logic trigger_input
);
    // idle low
    // the line rests low between pulses, as the pad pull-down would leave it
    initial trigger_input = 1'b0;

    // pulse wide enough for the two-flop synchroniser to see it
    // no window check; drives the pulse in the open or the closed window alike
    // caller picks the moment; a late caller may delay by dly cycles
    task automatic send(input int dly);
        repeat (dly + 1) @(posedge clk);
        trigger_input <= 1'b1;
        repeat (4) @(posedge clk);
        trigger_input <= 1'b0;
    endtask
endmodule

// File: wwds_pkg.sv
package wwds_pkg;

    // ----------------------------------------------------------------
    // timing, clock 10 MHz
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    // plain defaults; set them to the timing the board really needs
    localparam int TRIGGER_TIMEOUT_US = 1_000;
    localparam int DOUBLE_PULSE_US = 100;
    localparam int FAULT_HOLD_US = 100;
    localparam int RESET_DELAY_US = 1_000;
    localparam int TIMEOUT_CYC = TRIGGER_TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int DPULSE_CYC = DOUBLE_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int HOLD_CYC = FAULT_HOLD_US * (CLK_HZ / 1_000_000);
    localparam int RDLY_CYC = RESET_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W = 20;

    // ----------------------------------------------------------------
    // register map (word offsets are byte addresses)
    // ----------------------------------------------------------------
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] CFG_OFS = 4'h8;
    localparam int CTRL_USE_PIN_BIT = 0;
    localparam int CTRL_SW_EN_BIT = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // activation mode selected by the sense input
    typedef enum logic [1:0]
    {
        WWDS_MODE_UNUSED = 2'b00,
        WWDS_MODE_ALWAYS = 2'b01,
        WWDS_MODE_LOAD = 2'b10
    } wwds_mode_type;

    // gray codes along idle -> open -> closed -> fault
    typedef enum logic [1:0]
    {
        WWDS_IDLE = 2'b00,
        WWDS_OPEN = 2'b01,
        WWDS_CLOSED = 2'b11,
        WWDS_FAULT = 2'b10
    } wwds_state_type;

    typedef struct packed
    {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } wwds_bus_req_type;

    typedef struct packed
    {
        logic [31:0] readdata;
        logic waitrequest;
        logic readdatavalid;
    } wwds_bus_rsp_type;

    // load sense comparator pair
    typedef struct packed
    {
        logic above_act;
        logic below_deact;
    } wwds_sense_type;

endpackage

// File: wwds_supervisor.sv
`timescale 1ns/1ns
// Functional notes
// - monitoring start enters open window and starts timing
// - trigger rising edge in open window moves to closed window
// - closed window returns to open after double-pulse window time
// - fault output high while cycling between open and closed
// - no trigger within time-out from start or last trigger gives fault
// - deactivation with output high clears cycle count and elapsed time
// - fault holds output low for hold time, then open with output high
// - deactivation while low keeps output low until hold time ends
// - second trigger in closed window before window time gives fault
// - undervoltage returns to initial state, recovery goes via power-on reset
// - sense input selects unused, always active or load-sense mode
// - load-sense activates at activation level, off at deactivation level
// - enable low disables sensing and monitoring regardless of config
// - enable high lets activation follow the configuration input
// - enable pin weakly pulled low; board should tie it firmly
// - trigger input weakly pulled low, floating reads low
// - triggers accepted only when active, output high and timing runs
// - combined output is AND of reset output and fault output
module wwds_supervisor
    import wwds_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int DPULSE_CYCLES = DPULSE_CYC,
    parameter int HOLD_CYCLES = HOLD_CYC,
    parameter int RDLY_CYCLES = RDLY_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic trigger_input,
    input wire logic enable_pin,
    input wire wwds_mode_type activation_sense_input,
    input wire wwds_sense_type load_sense,
    input wire logic undervoltage_ok,
    input wire wwds_bus_req_type bus_req,
    output wwds_bus_rsp_type bus_rsp,
    output logic watchdog_fault_output,
    output logic supervisor_reset_output,
    output logic combined_supervisor_output
);

    // ----------------------------------------------------------------
    // state record
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic [1:0] trig_sync;
        logic [1:0] en_sync;
        logic [1:0] uv_sync;
        logic [3:0] cfg_sync;
        logic [3:0] sense_sync;
        logic trig_prev;
        logic load_on;
        wwds_state_type state;
        logic [CNT_W-1:0] win_cnt;
        logic [CNT_W-1:0] tmo_cnt;
        logic [CNT_W-1:0] rst_cnt;
        logic rst_out;
        logic fault_out;
        logic comb_out;
        logic [1:0] ctrl;
        logic [7:0] fault_count;
        wwds_bus_rsp_type rsp;
    } wwds_regs_type;

    wwds_regs_type r;
    wwds_regs_type next_r;
    logic en_pin_s;
    logic uv_s;
    wwds_mode_type cfg_s;
    wwds_sense_type sense_s;
    logic enabled;
    logic active;
    logic trig_edge;
    logic [31:0] rd_word;

    // second sync stage only feeds logic
    assign en_pin_s = r.en_sync[1];
    assign uv_s = r.uv_sync[1];
    assign cfg_s = wwds_mode_type'(r.cfg_sync[3:2]);
    assign sense_s = r.sense_sync[3:2];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.trig_sync = {r.trig_sync[0], trigger_input};
        next_r.en_sync = {r.en_sync[0], enable_pin};
        next_r.uv_sync = {r.uv_sync[0], undervoltage_ok};
        next_r.cfg_sync = {r.cfg_sync[1:0], activation_sense_input};
        next_r.sense_sync = {r.sense_sync[1:0], load_sense};
        next_r.trig_prev = r.trig_sync[1];
        // enable gate
        // the pin pull-down lives in the pad; a floating pin arrives low
        // enable gate
        enabled = r.ctrl[CTRL_USE_PIN_BIT] ? en_pin_s : r.ctrl[CTRL_SW_EN_BIT];
        if (!enabled)
        begin
            next_r.load_on = 1'b0;
        end
        else if (sense_s.above_act)
        begin
            next_r.load_on = 1'b1;
        end
        else if (sense_s.below_deact)
        begin
            next_r.load_on = 1'b0;
        end
        case (cfg_s)
            WWDS_MODE_ALWAYS: active = enabled && r.rst_out;
            WWDS_MODE_LOAD: active = enabled && r.load_on && r.rst_out;
            default: active = 1'b0;
        endcase
        trig_edge = r.trig_sync[1] && !r.trig_prev && active && r.fault_out;
        if (!uv_s)
        begin
            next_r.rst_out = 1'b0;
            next_r.rst_cnt = '0;
        end
        else if (!r.rst_out)
        begin
            if (r.rst_cnt >= CNT_W'(RDLY_CYCLES - 1))
            begin
                next_r.rst_out = 1'b1;
            end
            else
            begin
                next_r.rst_cnt = r.rst_cnt + 1'b1;
            end
        end
        next_r.win_cnt = r.win_cnt + 1'b1;
        next_r.tmo_cnt = r.tmo_cnt + 1'b1;
        case (r.state)
            WWDS_IDLE:
            begin
                next_r.win_cnt = '0;
                next_r.tmo_cnt = '0;
                next_r.fault_out = 1'b1;
                if (active)
                begin
                    next_r.state = WWDS_OPEN;
                end
            end
            WWDS_OPEN:
            begin
                if (trig_edge)
                begin
                    next_r.state = WWDS_CLOSED;
                    next_r.win_cnt = '0;
                    next_r.tmo_cnt = '0;
                end
                else if (r.tmo_cnt >= CNT_W'(TIMEOUT_CYCLES - 1))
                begin
                    next_r.state = WWDS_FAULT;
                    next_r.fault_out = 1'b0;
                    next_r.win_cnt = '0;
                    next_r.fault_count = r.fault_count + 1'b1;
                end
            end
            WWDS_CLOSED:
            begin
                if (trig_edge)
                begin
                    next_r.state = WWDS_FAULT;
                    next_r.fault_out = 1'b0;
                    next_r.win_cnt = '0;
                    next_r.fault_count = r.fault_count + 1'b1;
                end
                else if (r.win_cnt >= CNT_W'(DPULSE_CYCLES - 1))
                begin
                    next_r.state = WWDS_OPEN;
                    next_r.win_cnt = '0;
                end
            end
            default:
            begin
                if (r.win_cnt >= CNT_W'(HOLD_CYCLES - 1))
                begin
                    next_r.state = active ? WWDS_OPEN : WWDS_IDLE;
                    next_r.fault_out = 1'b1;
                    next_r.win_cnt = '0;
                    next_r.tmo_cnt = '0;
                end
            end
        endcase
        if (!active && r.state != WWDS_FAULT)
        begin
            next_r.state = WWDS_IDLE;
            next_r.win_cnt = '0;
            next_r.tmo_cnt = '0;
            next_r.fault_out = 1'b1;
        end
        if (!uv_s)
        begin
            next_r.state = WWDS_IDLE;
            next_r.win_cnt = '0;
            next_r.tmo_cnt = '0;
            next_r.fault_out = 1'b1;
        end
        next_r.comb_out = next_r.rst_out && next_r.fault_out;
        // bus slave: one wait cycle, then answer
        rd_word = UNMAPPED_READ;
        if (bus_req.address == CTRL_OFS)
        begin
            rd_word = {30'h0000_0000, r.ctrl};
        end
        else if (bus_req.address == STATUS_OFS)
        begin
            rd_word = {24'h00_0000, r.fault_count[3:0], r.state, r.rst_out, r.fault_out};
        end
        else if (bus_req.address == CFG_OFS)
        begin
            rd_word = {28'h000_0000, active, r.load_on, cfg_s};
        end
        next_r.rsp.readdatavalid = 1'b0;
        next_r.rsp.waitrequest = 1'b1;
        if ((bus_req.read || bus_req.write) && r.rsp.waitrequest)
        begin
            next_r.rsp.waitrequest = 1'b0;
            next_r.rsp.readdata = rd_word;
        end
        // the write lands on the edge where the master sees waitrequest low, not one earlier
        if (bus_req.write && !r.rsp.waitrequest && bus_req.address == CTRL_OFS)
        begin
            next_r.ctrl = bus_req.writedata[1:0];
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.state <= WWDS_IDLE;
            r.fault_out <= 1'b1;
            r.ctrl <= CTRL_RESET[1:0];
            r.rsp.waitrequest <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign bus_rsp = r.rsp;
    assign watchdog_fault_output = r.fault_out;
    assign supervisor_reset_output = r.rst_out;
    assign combined_supervisor_output = r.comb_out;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // double pulse fault
    fault_on_double_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (r.state == WWDS_CLOSED && trig_edge && uv_s && active) |=> (r.state == WWDS_FAULT && !r.fault_out))
        else $error("double pulse did not fault");
    output_high_cycle_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (r.state == WWDS_OPEN || r.state == WWDS_CLOSED) |-> r.fault_out)
        else $error("fault output low while cycling");
    combined_and_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            $past(rst_n) |-> (r.comb_out == (r.rst_out && r.fault_out)))
        else $error("combined output mismatch");
    open_to_closed_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (r.state == WWDS_OPEN && trig_edge && uv_s && active) |=> r.state == WWDS_CLOSED)
        else $error("trigger not taken in open window");
    no_trigger_inactive_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (!active || !r.fault_out) |-> !trig_edge)
        else $error("trigger accepted while inactive");
    fault_holds_low_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            ($fell(r.fault_out) && uv_s) |=> !r.fault_out || !uv_s)
        else $error("fault released early");
    disabled_idle_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (!enabled && r.state != WWDS_FAULT) |=> (r.state == WWDS_IDLE || r.state == WWDS_FAULT))
        else $error("monitoring while disabled");
    uv_initial_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            !uv_s |=> (r.state == WWDS_IDLE && !r.rst_out))
        else $error("undervoltage did not reset watchdog");
    closed_returns_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (r.state == WWDS_CLOSED && r.win_cnt >= CNT_W'(DPULSE_CYCLES - 1) && !trig_edge && active && uv_s)
            |=> r.state == WWDS_OPEN)
        else $error("closed window did not reopen");
    start_open_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (r.state == WWDS_IDLE && active && uv_s) |=> (r.state == WWDS_OPEN && r.tmo_cnt == '0))
        else $error("monitoring did not start in open window");
    timeout_fault_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (r.state == WWDS_OPEN && !trig_edge && r.tmo_cnt >= CNT_W'(TIMEOUT_CYCLES - 1) && active && uv_s)
            |=> (r.state == WWDS_FAULT && !r.fault_out))
        else $error("time-out did not fault");
    hold_release_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (r.state == WWDS_FAULT && r.win_cnt >= CNT_W'(HOLD_CYCLES - 1) && active && uv_s)
            |=> (r.state == WWDS_OPEN && r.fault_out))
        else $error("fault hold did not end in open window");
    hold_not_early_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (r.state == WWDS_FAULT && r.win_cnt < CNT_W'(HOLD_CYCLES - 1) && uv_s)
            |=> (r.state == WWDS_FAULT && !r.fault_out))
        else $error("fault hold ended early");
    deact_clears_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (!active && r.state != WWDS_FAULT) |=> (r.tmo_cnt == '0 && r.win_cnt == '0 && r.fault_out))
        else $error("deactivation kept elapsed time");
    mode_unused_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (cfg_s == WWDS_MODE_UNUSED) |-> !active)
        else $error("active in unused mode");
    load_gate_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (cfg_s == WWDS_MODE_LOAD && !r.load_on) |-> !active)
        else $error("active without load current");
    load_hold_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (enabled && !sense_s.above_act && !sense_s.below_deact) |=> (r.load_on == $past(r.load_on)))
        else $error("load latch moved between thresholds");
    sense_stop_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            !enabled |=> !r.load_on)
        else $error("load sensing while disabled");
    enable_follows_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            (enabled && cfg_s == WWDS_MODE_ALWAYS && r.rst_out) |-> active)
        else $error("enabled always mode not active");
    reset_gate_a:
        assert property (@(posedge clk) disable iff (!rst_n)
            !r.rst_out |-> !active)
        else $error("active during power-on reset");

endmodule

// File: wwds_supervisor_tb_top.sv
`timescale 1ns/1ns
module wwds_supervisor_tb_top
    import wwds_pkg::*;
;
    localparam int TO = 40;
    localparam int DP = 10;
    localparam int HD = 8;
    localparam int RD = 5;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic trig;
    logic enable_pin = 1'b0;
    wwds_mode_type mode = WWDS_MODE_UNUSED;
    wwds_sense_type sense = '0;
    logic uv_ok = 1'b0;
    wwds_bus_req_type req = '0;
    wwds_bus_rsp_type rsp;
    logic fault_out;
    logic rst_out;
    logic comb_out;
    int errors = 0;
    int n_checks = 0;
    logic [31:0] rd;

    // ----------------------------------------------------------------
    // clock, design and partner
    // ----------------------------------------------------------------
    always #50 clk = ~clk;

    wwds_supervisor #(.TIMEOUT_CYCLES(TO), .DPULSE_CYCLES(DP), .HOLD_CYCLES(HD), .RDLY_CYCLES(RD))
    wwds_supervisor_inst (.clk(clk), .rst_n(rst_n), .trigger_input(trig), .enable_pin(enable_pin),
        .activation_sense_input(mode), .load_sense(sense), .undervoltage_ok(uv_ok), .bus_req(req),
        .bus_rsp(rsp), .watchdog_fault_output(fault_out), .supervisor_reset_output(rst_out),
        .combined_supervisor_output(comb_out));

    wwds_mcu_model wwds_mcu_model_inst (.clk(clk), .trigger_input(trig));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // rsp is read right after each rising edge, before the design's registers move,
    // so it is the value that edge sampled; only the watchdog ends a wait
    task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] d);
        @(posedge clk);
        req.address <= a;
        req.write <= wr;
        req.read <= ~wr;
        req.writedata <= wd;
        @(posedge clk);
        while (rsp.waitrequest !== 1'b0)
        begin
            @(posedge clk);
        end
        d = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    // compare state, reset output and fault output as seen in the status word
    task automatic chk_st(input wwds_state_type s, input logic r, input logic f);
        logic [31:0] d;
        bus(STATUS_OFS, 1'b0, 32'h0000_0000, d);
        chk("status", {28'h000_0000, d[3:0]}, {28'h000_0000, s, r, f});
    endtask

    // pins compared mid-cycle; return on a rising edge so stimulus stays on that edge
    task automatic chk_pins(input logic f, input logic r, input logic c);
        @(negedge clk);
        chk("fault_pin", {31'h0, fault_out}, {31'h0, f});
        chk("reset_pin", {31'h0, rst_out}, {31'h0, r});
        chk("comb_pin", {31'h0, comb_out}, {31'h0, c});
        @(posedge clk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ----------------------------------------------------------------
    // watchdog against a hung run
    // ----------------------------------------------------------------
    initial
    begin
        cyc(3000);
        errors++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial
    begin
        cyc(5);
        rst_n <= 1'b1;
        bus(CTRL_OFS, 1'b0, 32'h0000_0000, rd);
        chk("ctrl_reset", rd, CTRL_RESET);
        bus(4'hc, 1'b1, 32'hffff_ffff, rd);
        bus(4'hc, 1'b0, 32'h0000_0000, rd);
        chk("unmapped", rd, UNMAPPED_READ);
        chk_st(WWDS_IDLE, 1'b0, 1'b1);
        uv_ok <= 1'b1;
        cyc(RD + 10);
        chk_st(WWDS_IDLE, 1'b1, 1'b1);
        enable_pin <= 1'b1;
        mode <= WWDS_MODE_ALWAYS;
        cyc(8);
        chk_st(WWDS_OPEN, 1'b1, 1'b1);
        wwds_mcu_model_inst.send(0);
        chk_st(WWDS_CLOSED, 1'b1, 1'b1);
        cyc(DP + 4);
        chk_st(WWDS_OPEN, 1'b1, 1'b1);
        // disable well before the time-out that the first trigger started
        cyc(8);
        enable_pin <= 1'b0;
        cyc(6);
        chk_st(WWDS_IDLE, 1'b1, 1'b1);
        enable_pin <= 1'b1;
        cyc(30);
        chk_st(WWDS_OPEN, 1'b1, 1'b1);
        wwds_mcu_model_inst.send(0);
        cyc(TO - 8);
        chk_pins(1'b1, 1'b1, 1'b1);
        cyc(9);
        chk_pins(1'b0, 1'b1, 1'b0);
        cyc(HD + 4);
        chk_st(WWDS_OPEN, 1'b1, 1'b1);
        wwds_mcu_model_inst.send(0);
        wwds_mcu_model_inst.send(1);
        cyc(2);
        chk_pins(1'b0, 1'b1, 1'b0);
        enable_pin <= 1'b0;
        cyc(2);
        chk_pins(1'b0, 1'b1, 1'b0);
        cyc(HD + 4);
        chk_st(WWDS_IDLE, 1'b1, 1'b1);
        enable_pin <= 1'b1;
        mode <= WWDS_MODE_LOAD;
        cyc(6);
        chk_st(WWDS_IDLE, 1'b1, 1'b1);
        sense <= '{above_act: 1'b1, below_deact: 1'b0};
        cyc(6);
        chk_st(WWDS_OPEN, 1'b1, 1'b1);
        bus(CFG_OFS, 1'b0, 32'h0000_0000, rd);
        chk("cfg", rd, 32'h0000_000e);
        sense <= '0;
        cyc(6);
        chk_st(WWDS_OPEN, 1'b1, 1'b1);
        sense <= '{above_act: 1'b0, below_deact: 1'b1};
        cyc(6);
        chk_st(WWDS_IDLE, 1'b1, 1'b1);
        sense <= '0;
        mode <= WWDS_MODE_ALWAYS;
        bus(CTRL_OFS, 1'b1, 32'h0000_0000, rd);
        bus(CTRL_OFS, 1'b0, 32'h0000_0000, rd);
        chk("ctrl_rw", rd, 32'h0000_0000);
        cyc(6);
        chk_st(WWDS_IDLE, 1'b1, 1'b1);
        bus(CTRL_OFS, 1'b1, 32'h0000_0002, rd);
        cyc(6);
        chk_st(WWDS_OPEN, 1'b1, 1'b1);
        uv_ok <= 1'b0;
        cyc(6);
        chk_st(WWDS_IDLE, 1'b0, 1'b1);
        chk_pins(1'b1, 1'b0, 1'b0);
        // one time-out fault and one double-pulse fault so far
        bus(STATUS_OFS, 1'b0, 32'h0000_0000, rd);
        chk("fault_count", {28'h000_0000, rd[7:4]}, 32'h0000_0002);
        end_of_test();
    end
endmodule
